// ===== inc/tst_regs_map.vh
// Constants of the timestamp, status and temperature register group.
// Assumes a 100 MHz device clock and a byte-wide register read port.
// Overview of operation
// - A 24-bit timestamp counter runs in every power mode.
// - The timestamp advances by one count every 39 us.
// - The timestamp starts at zero and wraps to zero after all ones.
// - A burst read from the data registers returns the timestamp captured at start.
// - During buffer readout the timestamp shadow is recaptured at each new frame.
// - The timestamp sits at bytes 0x18-0x1a, low byte first, reset zero.
// - Status bit 6 sets on new rate data, clears on any data byte read.
// - Status bit 4 is 0 during a memory write, 1 when ready.
// - Status bit 3 shows fast offset compensation has completed.
// - Status bit 1 is 1 only after a successful self-test.
// - Status bit 0 sets on power-on or soft reset, clears when status read.
// - Interrupt flags: watermark at bit 6, full at bit 5, data ready bit 4.
// - An interrupt flag sets only when its function is enabled and triggers.
// - An interrupt flag reads 1 while active and 0 while inactive.
// - The 16-bit temperature word is valid only in gyro normal mode.
// - Temperature is two's complement, zero is 23 C, 1/512 K per count.
// - Temperature resets to 0x8000, a code used only for invalid.
// - In gyro normal mode the temperature updates about every 10 ms.
// - Gyro suspended, thermal sensor normal: update every 1.28 s.
// - Gyro fast start-up, thermal sensor suspended: still update every 1.28 s.
// - Gyro and thermal sensor both suspended: no temperature measurement.
// - Gyro power field: 00 suspend, 01 normal, 11 fast start-up, 10 reserved.
`ifndef TST_REGS_MAP_VH
`define TST_REGS_MAP_VH

`define TST_ADDR_DATA_FIRST   8'h12
`define TST_ADDR_DATA_LAST    8'h17
`define TST_ADDR_TS_0         8'h18
`define TST_ADDR_TS_1         8'h19
`define TST_ADDR_TS_2         8'h1a
`define TST_ADDR_STATUS       8'h1b
`define TST_ADDR_INT_FLAGS    8'h1d
`define TST_ADDR_TEMP_LSB     8'h20
`define TST_ADDR_TEMP_MSB     8'h21

`define TST_ST_DRDY_BIT       6
`define TST_ST_NVM_BIT        4
`define TST_ST_FOC_BIT        3
`define TST_ST_SELFTEST_BIT   1
`define TST_ST_POR_BIT        0
`define TST_INT_FWM_BIT       6
`define TST_INT_FFULL_BIT     5
`define TST_INT_DRDY_BIT      4

`define TST_TS_RESET          24'h000000
`define TST_TS_MAX            24'hffffff
`define TST_TEMP_RESET        16'h8000
`define TST_TEMP_SUBST        16'h8001
`define TST_RESERVED_RD       8'h00

`define TST_PMU_SUSPEND       2'h0
`define TST_PMU_NORMAL        2'h1
`define TST_PMU_RESERVED      2'h2
`define TST_PMU_FAST_START    2'h3

`define TST_CLK_PERIOD_NS     10
`define TST_TS_STEP_NS        39000
`define TST_TS_STEP_CYCLES    (`TST_TS_STEP_NS / `TST_CLK_PERIOD_NS)
`define TST_TEMP_FAST_US      10000
`define TST_TEMP_FAST_CYCLES  (`TST_TEMP_FAST_US * 1000 / `TST_CLK_PERIOD_NS)
`define TST_TEMP_SLOW_MS      1280
`define TST_TEMP_SLOW_CYCLES  (`TST_TEMP_SLOW_MS * 100000)

`endif

// ===== rtl/tst_tick_div.v
// Periodic tick generator: one-cycle pulse every LIMIT enabled clocks.
// Assumes a synchronous active-high reset and a shared clock enable.
`timescale 1ns/1ns
module tst_tick_div #(
	parameter integer LIMIT = 4
) (
	clk,
	reset,
	ce,
	run,
	tick
);
	input  wire        clk;
	input  wire        reset;
	input  wire        ce;
	input  wire        run;
	output wire        tick;

	localparam [31:0] LAST32 = LIMIT - 1;
	localparam [26:0] LAST   = LAST32[26:0];

	reg  [26:0] cnt_ff;
	reg  [26:0] nxt_cnt;

	// Count restarts whenever run drops, so a new schedule begins a full period
	always @* begin
		if (!run)
			nxt_cnt = 27'h0000000;
		else if (cnt_ff == LAST)
			nxt_cnt = 27'h0000000;
		else
			nxt_cnt = cnt_ff + 27'h0000001;
	end

	always @(posedge clk) begin
		if (reset)
			cnt_ff <= 27'h0000000;
		else if (ce)
			cnt_ff <= nxt_cnt;
	end

	assign tick = ce & run & (cnt_ff == LAST);
endmodule

// ===== rtl/tst_regs.v
// Timestamp counter, sensor status, interrupt flags and temperature registers.
// Assumes all source inputs come from logic on clk; reads arrive as byte strobes.
`timescale 1ns/1ns
`include "tst_regs_map.vh"
module tst_regs #(
	parameter integer TEMP_FAST_CYCLES = `TST_TEMP_FAST_CYCLES,
	parameter integer TEMP_SLOW_CYCLES = `TST_TEMP_SLOW_CYCLES
) (
	clk,
	reset,
	ce,
	rd_en,
	rd_addr,
	rd_data,
	burst_start,
	burst_addr,
	burst_end,
	fifo_frame_start,
	gyro_data_new,
	soft_reset,
	nvm_busy,
	foc_done,
	self_test_ok,
	int_en,
	int_trig,
	gyro_pmu_status,
	thermal_sensor_power,
	temp_sample,
	temp_sample_valid,
	temp_meas_req,
	temp_word_valid,
	timestamp
);
	input  wire        clk;
	input  wire        reset;
	input  wire        ce;
	input  wire        rd_en;
	input  wire [7:0]  rd_addr;
	output wire [7:0]  rd_data;
	input  wire        burst_start;
	input  wire [7:0]  burst_addr;
	input  wire        burst_end;
	input  wire        fifo_frame_start;
	input  wire        gyro_data_new;
	input  wire        soft_reset;
	input  wire        nvm_busy;
	input  wire        foc_done;
	input  wire        self_test_ok;
	input  wire [2:0]  int_en;
	input  wire [2:0]  int_trig;
	input  wire [1:0]  gyro_pmu_status;
	input  wire        thermal_sensor_power;
	input  wire [15:0] temp_sample;
	input  wire        temp_sample_valid;
	output wire        temp_meas_req;
	output wire        temp_word_valid;
	output wire [23:0] timestamp;

	// Timestamp state
	reg  [23:0] ts_ff;
	reg  [23:0] nxt_ts;
	reg  [23:0] ts_shadow_ff;
	reg  [23:0] nxt_ts_shadow;
	reg         shadow_use_ff;
	reg         nxt_shadow_use;
	wire        ts_tick;

	// Status state
	reg         drdy_ff;
	reg         nxt_drdy;
	reg         por_ff;
	reg         nxt_por;
	reg         nvm_rdy_ff;
	reg         foc_rdy_ff;
	reg         st_ok_ff;

	// Interrupt flags
	reg  [2:0]  int_flag_ff;
	wire [2:0]  nxt_int_flag;

	// Temperature state
	reg  [15:0] temp_ff;
	reg  [15:0] nxt_temp;
	reg         meas_pend_ff;
	reg         nxt_meas_pend;
	wire        fast_tick;
	wire        slow_tick;
	wire        gyro_normal;
	wire        gyro_suspend;
	wire        gyro_fast;
	wire        run_fast;
	wire        run_slow;
	wire        meas_start;

	// Read port
	reg  [7:0]  rd_data_ff;
	reg  [7:0]  nxt_rd_data;
	wire [23:0] ts_view;
	wire [7:0]  status_byte;
	wire [7:0]  int_byte;
	wire        rd_data_reg;
	wire        rd_status;

	// ---------------- Timestamp ----------------

	// Never gated by power mode: the time base must stay monotonic across modes
	tst_tick_div #(
		.LIMIT (`TST_TS_STEP_CYCLES)
	) u_ts_div (
		.clk   (clk),
		.reset (reset),
		.ce    (ce),
		.run   (1'b1),
		.tick  (ts_tick)
	);

	always @* begin
		nxt_ts = ts_ff;
		if (ts_tick) begin
			if (ts_ff == `TST_TS_MAX)
				nxt_ts = `TST_TS_RESET;
			else
				nxt_ts = ts_ff + 24'h000001;
		end
	end

	// A burst that opens on the data block freezes the view for the whole burst;
	// a new buffer frame refreshes it so each frame carries its own time.
	always @* begin
		nxt_ts_shadow  = ts_shadow_ff;
		nxt_shadow_use = shadow_use_ff;
		if (burst_start) begin
			if (burst_addr >= `TST_ADDR_DATA_FIRST && burst_addr <= `TST_ADDR_TS_2) begin
				nxt_ts_shadow  = ts_ff;
				nxt_shadow_use = 1'b1;
			end else begin
				nxt_shadow_use = 1'b0;
			end
		end else if (burst_end) begin
			nxt_shadow_use = 1'b0;
		end
		if (fifo_frame_start) begin
			nxt_ts_shadow  = ts_ff;
			nxt_shadow_use = 1'b1;
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			ts_ff         <= `TST_TS_RESET;
			ts_shadow_ff  <= `TST_TS_RESET;
			shadow_use_ff <= 1'b0;
		end else if (ce) begin
			ts_ff         <= nxt_ts;
			ts_shadow_ff  <= nxt_ts_shadow;
			shadow_use_ff <= nxt_shadow_use;
		end
	end

	assign ts_view   = shadow_use_ff ? ts_shadow_ff : ts_ff;
	assign timestamp = ts_ff;

	// ---------------- Sensor status ----------------

	assign rd_data_reg = rd_en && rd_addr >= `TST_ADDR_DATA_FIRST &&
		rd_addr <= `TST_ADDR_DATA_LAST;
	assign rd_status   = rd_en && rd_addr == `TST_ADDR_STATUS;

	// New data in the same cycle as a read wins, so no sample goes unflagged
	always @* begin
		nxt_drdy = drdy_ff;
		if (rd_data_reg)
			nxt_drdy = 1'b0;
		if (gyro_data_new)
			nxt_drdy = 1'b1;
	end

	always @* begin
		nxt_por = por_ff;
		if (rd_status)
			nxt_por = 1'b0;
		if (soft_reset)
			nxt_por = 1'b1;
	end

	always @(posedge clk) begin
		if (reset) begin
			drdy_ff    <= 1'b0;
			por_ff     <= 1'b1;
			nvm_rdy_ff <= 1'b0;
			foc_rdy_ff <= 1'b0;
			st_ok_ff   <= 1'b0;
		end else if (ce) begin
			drdy_ff    <= nxt_drdy;
			por_ff     <= nxt_por;
			nvm_rdy_ff <= ~nvm_busy;
			foc_rdy_ff <= foc_done;
			st_ok_ff   <= self_test_ok;
		end
	end

	assign status_byte = {1'b0, drdy_ff, 1'b0, nvm_rdy_ff, foc_rdy_ff, 1'b0, st_ok_ff, por_ff};

	// ---------------- Interrupt flags ----------------

	// Index 2 watermark, 1 full, 0 data ready; flags follow the live condition
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_int
			assign nxt_int_flag[gi] = int_en[gi] & int_trig[gi];
		end
	endgenerate

	always @(posedge clk) begin
		if (reset)
			int_flag_ff <= 3'h0;
		else if (ce)
			int_flag_ff <= nxt_int_flag;
	end

	assign int_byte = {1'b0, int_flag_ff, 4'h0};

	// ---------------- Temperature ----------------

	assign gyro_normal  = gyro_pmu_status == `TST_PMU_NORMAL;
	assign gyro_suspend = gyro_pmu_status == `TST_PMU_SUSPEND;
	assign gyro_fast    = gyro_pmu_status == `TST_PMU_FAST_START;

	// Reserved gyro mode and the all-suspended case leave both schedules idle
	assign run_fast = gyro_normal;
	assign run_slow = (gyro_suspend & thermal_sensor_power) | gyro_fast;

	tst_tick_div #(
		.LIMIT (TEMP_FAST_CYCLES)
	) u_temp_fast (
		.clk   (clk),
		.reset (reset),
		.ce    (ce),
		.run   (run_fast),
		.tick  (fast_tick)
	);

	tst_tick_div #(
		.LIMIT (TEMP_SLOW_CYCLES)
	) u_temp_slow (
		.clk   (clk),
		.reset (reset),
		.ce    (ce),
		.run   (run_slow),
		.tick  (slow_tick)
	);

	assign meas_start    = fast_tick | slow_tick;
	assign temp_meas_req = meas_start;

	// A result is stored only for a measurement this block asked for
	always @* begin
		nxt_meas_pend = meas_pend_ff;
		nxt_temp      = temp_ff;
		if (temp_sample_valid && meas_pend_ff) begin
			nxt_meas_pend = 1'b0;
			// The invalid code is reserved, so a raw 0x8000 is moved one count up
			if (temp_sample == `TST_TEMP_RESET)
				nxt_temp = `TST_TEMP_SUBST;
			else
				nxt_temp = temp_sample;
		end
		if (meas_start)
			nxt_meas_pend = 1'b1;
		if (!run_fast && !run_slow)
			nxt_meas_pend = 1'b0;
	end

	always @(posedge clk) begin
		if (reset) begin
			temp_ff      <= `TST_TEMP_RESET;
			meas_pend_ff <= 1'b0;
		end else if (ce) begin
			temp_ff      <= nxt_temp;
			meas_pend_ff <= nxt_meas_pend;
		end
	end

	assign temp_word_valid = gyro_normal && temp_ff != `TST_TEMP_RESET;

	// ---------------- Read port ----------------

	// Registered read data: one cycle from strobe to data, held until next read
	always @* begin
		nxt_rd_data = rd_data_ff;
		if (rd_en) begin
			case (rd_addr)
				`TST_ADDR_TS_0:      nxt_rd_data = ts_view[7:0];
				`TST_ADDR_TS_1:      nxt_rd_data = ts_view[15:8];
				`TST_ADDR_TS_2:      nxt_rd_data = ts_view[23:16];
				`TST_ADDR_STATUS:    nxt_rd_data = status_byte;
				`TST_ADDR_INT_FLAGS: nxt_rd_data = int_byte;
				`TST_ADDR_TEMP_LSB:  nxt_rd_data = temp_ff[7:0];
				`TST_ADDR_TEMP_MSB:  nxt_rd_data = temp_ff[15:8];
				default:             nxt_rd_data = `TST_RESERVED_RD;
			endcase
		end
	end

	always @(posedge clk) begin
		if (reset)
			rd_data_ff <= `TST_RESERVED_RD;
		else if (ce)
			rd_data_ff <= nxt_rd_data;
	end

	assign rd_data = rd_data_ff;
endmodule

// ===== test/tst_regs_properties.sv
// Port checker for the timestamp, status and temperature register group.
// Assumes ce stays high around reads and temperature schedules; data one cycle after strobe.
`timescale 1ns/1ns
module tst_regs_chk #(
	parameter int TEMP_FAST_CYCLES = 50,
	parameter int TEMP_SLOW_CYCLES = 200
) (
	input logic        clk,
	input logic        reset,
	input logic        ce,
	input logic        rd_en,
	input logic [7:0]  rd_addr,
	input logic [7:0]  rd_data,
	input logic        gyro_data_new,
	input logic        soft_reset,
	input logic        nvm_busy,
	input logic        foc_done,
	input logic        self_test_ok,
	input logic [2:0]  int_en,
	input logic [2:0]  int_trig,
	input logic [1:0]  gyro_pmu_status,
	input logic        thermal_sensor_power,
	input logic        temp_meas_req,
	input logic [23:0] timestamp
);
	logic [11:0] n_ff;
	logic [8:0]  q_ff;
	logic [2:0]  m_ff;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// Mode age saturates, so a schedule restart is told apart from a missed request
	always @(posedge clk) begin
		// Step age follows only enabled cycles, as the time base does
		if (reset)
			n_ff <= 12'h0;
		else if (ce)
			n_ff <= (n_ff == 12'hf3b) ? 12'h0 : n_ff + 12'h1;
		m_ff <= {gyro_pmu_status, thermal_sensor_power};
		if (reset || m_ff != {gyro_pmu_status, thermal_sensor_power})
			q_ff <= 9'h0;
		else if (q_ff != 9'h1ff)
			q_ff <= q_ff + 9'h1;
	end
	a_ts_period: assert property ($changed(timestamp) == ($past(n_ff) == 12'hf3b && $past(ce)))
		else $error("timestamp step period wrong");
	a_ts_increment: assert property ($changed(timestamp) |-> timestamp - $past(timestamp) == 24'h1)
		else $error("timestamp did not count by one");
	a_status_levels: assert property (rd_en && rd_addr == 8'h1b && !$past(reset) |=>
		rd_data[4:1] == {!$past(nvm_busy, 2), $past(foc_done, 2), 1'b0, $past(self_test_ok, 2)})
		else $error("status level bits wrong");
	a_por_clear: assert property (rd_en && rd_addr == 8'h1b && !soft_reset ##1
		rd_en && rd_addr == 8'h1b |=> !rd_data[0]) else $error("power-on flag not cleared");
	a_drdy_set: assert property (gyro_data_new ##1 rd_en && rd_addr == 8'h1b |=> rd_data[6])
		else $error("data-ready flag not set");
	a_drdy_clear: assert property (rd_en && rd_addr >= 8'h12 && rd_addr <= 8'h17 && !gyro_data_new
		##1 rd_en && rd_addr == 8'h1b |=> !rd_data[6]) else $error("data-ready flag not cleared");
	a_int_flags: assert property (rd_en && rd_addr == 8'h1d && !$past(reset) |=>
		rd_data == {1'b0, $past(int_en & int_trig, 2), 4'h0}) else $error("interrupt flags wrong");
	a_temp_modes: assert property (temp_meas_req |-> gyro_pmu_status == 2'h1 ||
		gyro_pmu_status == 2'h3 || (gyro_pmu_status == 2'h0 && thermal_sensor_power))
		else $error("measurement in a mode without schedule");
	a_temp_fast: assert property (temp_meas_req && gyro_pmu_status == 2'h1 |->
		##TEMP_FAST_CYCLES (temp_meas_req || q_ff < TEMP_FAST_CYCLES)) else $error("fast period");
	a_temp_slow: assert property (temp_meas_req && gyro_pmu_status != 2'h1 |->
		##TEMP_SLOW_CYCLES (temp_meas_req || q_ff < TEMP_SLOW_CYCLES)) else $error("slow period");
endmodule
bind tst_regs tst_regs_chk #(.TEMP_FAST_CYCLES(TEMP_FAST_CYCLES), .TEMP_SLOW_CYCLES(TEMP_SLOW_CYCLES))
	tst_regs_chk_inst (.clk(clk), .reset(reset), .ce(ce), .rd_en(rd_en), .rd_addr(rd_addr),
	.rd_data(rd_data), .gyro_data_new(gyro_data_new), .soft_reset(soft_reset),
	.nvm_busy(nvm_busy), .foc_done(foc_done), .self_test_ok(self_test_ok), .int_en(int_en),
	.int_trig(int_trig), .gyro_pmu_status(gyro_pmu_status),
	.thermal_sensor_power(thermal_sensor_power), .temp_meas_req(temp_meas_req),
	.timestamp(timestamp));

// ===== test/tst_temp_src.sv
// Temperature measurement source answering requests of the register group.
// Assumes one-cycle requests on clk; answers lat+2 cycles later.
`timescale 1ns/1ns
module tst_temp_src (
	input logic         clk,
	input logic         temp_meas_req,
	input logic [3:0]   lat,
	input logic [15:0]  value,
	output logic [15:0] temp_sample,
	output logic        temp_sample_valid
);
	int wait_cnt = -1;
	initial temp_sample = 16'h5a5a;
	initial temp_sample_valid = 1'b0;
	always @(posedge clk) begin
		temp_sample_valid <= 1'b0;
		// Released bus toggles, so stale data is never taken as a result
		temp_sample <= ~temp_sample;
		if (temp_meas_req)
			wait_cnt <= lat;
		else if (wait_cnt > 0)
			wait_cnt <= wait_cnt - 1;
		else if (wait_cnt == 0) begin
			temp_sample_valid <= 1'b1;
			temp_sample <= value;
			wait_cnt <= -1;
		end
	end
endmodule

// ===== test/tb_top.sv
// Self-checking bench of the register group with a measurement source.
// Assumes the design answers reads one cycle after the strobe.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top;
	logic clk = 0, reset = 1, rd_en = 0, burst_start = 0, burst_end = 0, fifo_frame_start = 0;
	logic gyro_data_new = 0, soft_reset = 0, nvm_busy = 0, foc_done = 0, self_test_ok = 0;
	logic thermal_sensor_power = 0, temp_sample_valid, temp_meas_req, temp_word_valid, ce = 1;
	logic [7:0] rd_addr = 0, burst_addr = 0, rd_data;
	logic [2:0] int_en = 0, int_trig = 0;
	logic [1:0] gyro_pmu_status = 0;
	logic [3:0] lat = 1;
	logic [15:0] temp_val = 0, temp_sample;
	logic [23:0] timestamp;
	int failures = 0, tests_run = 0, cyc = 0, nreq = 0;
	tst_regs #(.TEMP_FAST_CYCLES(50), .TEMP_SLOW_CYCLES(200)) tst_regs_inst (.clk(clk),
		.reset(reset), .ce(ce), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
		.burst_start(burst_start), .burst_addr(burst_addr), .burst_end(burst_end),
		.fifo_frame_start(fifo_frame_start), .gyro_data_new(gyro_data_new),
		.soft_reset(soft_reset), .nvm_busy(nvm_busy), .foc_done(foc_done),
		.self_test_ok(self_test_ok), .int_en(int_en), .int_trig(int_trig),
		.gyro_pmu_status(gyro_pmu_status), .thermal_sensor_power(thermal_sensor_power),
		.temp_sample(temp_sample), .temp_sample_valid(temp_sample_valid),
		.temp_meas_req(temp_meas_req), .temp_word_valid(temp_word_valid), .timestamp(timestamp));
	tst_temp_src tst_temp_src_inst (.clk(clk), .temp_meas_req(temp_meas_req), .lat(lat),
		.value(temp_val), .temp_sample(temp_sample), .temp_sample_valid(temp_sample_valid));
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= reset ? 0 : cyc + 1;
		if (temp_meas_req)
			nreq++;
	end
	task automatic summarize();
		if (failures == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic pulse(ref logic s);
		@(posedge clk) #1 s = 1;
		@(posedge clk) #1 s = 0;
	endtask
	// Two back-to-back reads, each result checked in its own cycle
	task automatic rd2(input logic [7:0] a, b, ea, eb);
		@(posedge clk) #1 rd_en = 1;
		rd_addr = a;
		@(posedge clk) #1 rd_addr = b;
		`CHK("rd_data", ea, rd_data)
		@(posedge clk) #1 rd_en = 0;
		`CHK("rd_data", eb, rd_data)
	endtask
	task automatic t_count(input logic [1:0] g, input logic th, input int n, e);
		gyro_pmu_status = g;
		thermal_sensor_power = th;
		@(posedge clk) #1 nreq = 0;
		repeat (n) @(posedge clk);
		#1 `CHK("nreq", e, nreq)
	endtask
	task automatic t_reset();
		rd2(8'h1b, 8'h1b, 8'h11, 8'h10);
		rd2(8'h20, 8'h21, 8'h00, 8'h80);
		rd2(8'h18, 8'h1a, 8'h00, 8'h00);
		rd2(8'h1d, 8'h1c, 8'h00, 8'h00);
		`CHK("temp_word_valid", 1'b0, temp_word_valid)
	endtask
	task automatic t_status();
		nvm_busy = 1;
		foc_done = 1;
		self_test_ok = 1;
		// New data right before a status read, then a data read right before another
		@(posedge clk) #1 gyro_data_new = 1;
		@(posedge clk) #1 gyro_data_new = 0;
		rd_en = 1;
		rd_addr = 8'h1b;
		@(posedge clk) #1 rd_addr = 8'h13;
		`CHK("rd_data", 8'h4a, rd_data)
		@(posedge clk) #1 rd_addr = 8'h1b;
		`CHK("rd_data", 8'h00, rd_data)
		@(posedge clk) #1 rd_en = 0;
		`CHK("rd_data", 8'h0a, rd_data)
		// New data and a data read in one cycle: the set must win
		@(posedge clk) #1 gyro_data_new = 1;
		rd_en = 1;
		rd_addr = 8'h12;
		@(posedge clk) #1 gyro_data_new = 0;
		rd_en = 0;
		rd2(8'h1b, 8'h12, 8'h4a, 8'h00);
		rd2(8'h1b, 8'h1b, 8'h0a, 8'h0a);
		pulse(soft_reset);
		nvm_busy = 0;
		rd2(8'h1b, 8'h1b, 8'h1b, 8'h1a);
		foc_done = 0;
		self_test_ok = 0;
		rd2(8'h1b, 8'h1d, 8'h10, 8'h00);
	endtask
	task automatic t_int();
		logic [7:0] e;
		for (int i = 0; i < 8; i++) begin
			int_en = i[2:0];
			int_trig = {i[0], i[2:1]};
			e = {1'b0, int_en & int_trig, 4'h0};
			rd2(8'h1d, 8'h1d, e, e);
		end
	endtask
	task automatic t_ts();
		wait (cyc >= 3800);
		burst_addr = 8'h12;
		pulse(burst_start);
		wait (cyc >= 3950);
		`CHK("timestamp", 24'h1, timestamp)
		rd2(8'h18, 8'h19, 8'h00, 8'h00);
		pulse(burst_end);
		rd2(8'h18, 8'h1a, 8'h01, 8'h00);
		wait (cyc >= 7780);
		pulse(fifo_frame_start);
		// Clock enable low across the second step: the count holds, then resumes late
		@(posedge clk) #1 ce = 0;
		repeat (30) @(posedge clk);
		#1 `CHK("timestamp", 24'h1, timestamp)
		ce = 1;
		wait (cyc >= 7850);
		rd2(8'h18, 8'h18, 8'h01, 8'h01);
		burst_addr = 8'h20;
		pulse(burst_start);
		rd2(8'h18, 8'h19, 8'h02, 8'h00);
	endtask
	task automatic t_temp();
		temp_val = 16'h0123;
		gyro_pmu_status = 2'h1;
		repeat (120) @(posedge clk);
		rd2(8'h20, 8'h21, 8'h23, 8'h01);
		`CHK("temp_word_valid", 1'b1, temp_word_valid)
		temp_val = 16'h8000;
		lat = 4'h9;
		repeat (70) @(posedge clk);
		rd2(8'h20, 8'h21, 8'h01, 8'h80);
		t_count(2'h0, 1'b0, 410, 0);
		t_count(2'h0, 1'b1, 410, 2);
		t_count(2'h3, 1'b0, 410, 2);
		t_count(2'h2, 1'b1, 410, 0);
		`CHK("temp_word_valid", 1'b0, temp_word_valid)
		t_count(2'h1, 1'b0, 110, 2);
	endtask
	initial begin
		repeat (6) @(posedge clk);
		#1 reset = 0;
		t_reset();
		t_status();
		t_int();
		t_ts();
		t_temp();
		summarize();
	end
	// Tests need about 10k cycles; twice that means a hang
	initial begin
		#200000;
		failures++;
		summarize();
	end
endmodule
